//--- hdl/pdm_top.sv
// Purpose: dma channel perf counters, revision word and identifier map
// Assumes: apb slave, zero wait state, activity strobes on pclk
// Notes:   pclk is the dma bus clock; all counting happens on it
`include "pdm_cfg.svh"

module pdm_top #(
	parameter logic [11:0] REV_VERSION = 12'h0a5, // arbitrary value
	parameter logic [3:0]  REV_VARIANT = 4'h3     // arbitrary value
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire pdm_pkg::pdm_word_t pwdata,
	output pdm_pkg::pdm_word_t    prdata,
	output logic                  pready,
	output logic                  pslverr,
	// channel activity
	input  wire logic             ch0_wr_init,
	input  wire logic             ch1_wr_init,
	input  wire logic             ch1_wr_data,
	input  wire logic             ch1_wr_stall,
	// peripheral handshakes
	input  wire logic [11:0]      periph_rx_req,
	input  wire logic [11:0]      periph_tx_req,
	// channel handshake view
	output logic [7:0]            chan_req,
	output logic [7:0]            chan_is_tx
);
	import pdm_pkg::*;

	// ********************
	// state
	// ********************
	pdm_top_st_t s_r;
	pdm_top_st_t s_nxt;

	pdm_lat_t max0;
	pdm_lat_t max1;

	logic setup;
	logic wr_take;
	logic clr0;
	logic clr1;

	// ********************
	// decode helpers
	// ********************
	function automatic logic is_psel_addr(logic [11:0] a);
		return a[11:5] == 7'(`PDM_OFF_PSEL_BASE >> 5);
	endfunction : is_psel_addr

	function automatic pdm_pid_t reset_psel(int n);
		return 5'(n);
	endfunction : reset_psel

	// unmapped or misaligned addresses flag pslverr and read zero
	function automatic logic addr_known(logic [11:0] a);
		logic k;
		k = 1'b0;
		if (a[1:0] == 2'h0) begin
			// only the select block is decoded as a range
			unique case (a)
				`PDM_OFF_PERF_CTRL,
				`PDM_OFF_CH0_WR_LAT,
				`PDM_OFF_CH1_WR_DAT,
				`PDM_OFF_CH1_WR_STL,
				`PDM_OFF_CH1_WR_LAT,
				`PDM_OFF_REV_INFO: begin
					k = 1'b1;
				end
				default: begin
					k = is_psel_addr(a);
				end
			endcase
		end
		return k;
	endfunction : addr_known

	// ********************
	// apb access
	// ********************
	assign setup   = psel && !penable;
	assign wr_take = psel && penable && s_r.pready && pwrite && !s_r.pslverr;

	// clear pulses: write one, reads of this word give zero
	// bit 1 also restarts the channel-1 data and stall counts
	assign clr0 = wr_take && paddr == `PDM_OFF_PERF_CTRL
		&& pwdata[`PDM_CH0_CLR_BIT];
	assign clr1 = wr_take && paddr == `PDM_OFF_PERF_CTRL
		&& pwdata[`PDM_CH1_CLR_BIT];

	always_comb begin
		s_nxt = s_r;
		s_nxt.seen = 1'b1;

		// answer staged in setup so the access phase is zero wait
		s_nxt.pready  = setup;
		s_nxt.pslverr = setup && !addr_known(paddr);

		if (setup) begin
			s_nxt.prdata = `PDM_RST_WORD;
			if (!pwrite) begin
				unique case (paddr)
					`PDM_OFF_CH1_WR_DAT: begin
						s_nxt.prdata = s_r.dat1;
					end
					`PDM_OFF_CH1_WR_STL: begin
						s_nxt.prdata = s_r.stl1;
					end
					`PDM_OFF_CH1_WR_LAT: begin
						s_nxt.prdata = {16'h0000, max1};
					end
					`PDM_OFF_CH0_WR_LAT: begin
						s_nxt.prdata = {16'h0000, max0};
					end
					`PDM_OFF_REV_INFO: begin
						// variant is reported only, never decoded
						s_nxt.prdata = {12'h000, REV_VARIANT, 4'h0, REV_VERSION};
					end
					default: begin
						if (is_psel_addr(paddr) && paddr[1:0] == 2'h0) begin
							s_nxt.prdata = {27'h0000000, s_r.psel[paddr[4:2]]};
						end
					end
				endcase
			end
		end

		// values above the last identifier are kept but route nothing
		if (wr_take && is_psel_addr(paddr)) begin
			s_nxt.psel[paddr[4:2]] = pwdata[4:0];
		end

		// set wins over clear: an event in the clear cycle counts
		s_nxt.dat1 = pdm_cnt_next(s_r.dat1, ch1_wr_data, clr1);
		s_nxt.stl1 = pdm_cnt_next(s_r.stl1, ch1_wr_stall, clr1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r         <= '0;
			s_r.psel[0] <= 5'h00;
			s_r.psel[1] <= 5'h01;
			s_r.psel[2] <= 5'h02;
			s_r.psel[3] <= 5'h03;
			s_r.psel[4] <= 5'h04;
			s_r.psel[5] <= 5'h05;
			s_r.psel[6] <= 5'h06;
			s_r.psel[7] <= 5'h07;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata  = s_r.prdata;
	assign pready  = s_r.pready;
	assign pslverr = s_r.pslverr;

	// ********************
	// latency trackers
	// ********************
	// both trackers are identical; only the busy input and the clear pulse differ
	pdm_lat_track u_lat0 (
		.pclk    (pclk),
		.presetn (presetn),
		.busy    (ch0_wr_init),
		.clr     (clr0),
		.max_lat (max0)
	);

	pdm_lat_track u_lat1 (
		.pclk    (pclk),
		.presetn (presetn),
		.busy    (ch1_wr_init),
		.clr     (clr1),
		.max_lat (max1)
	);

	// ********************
	// channel routing
	// ********************
	for (genvar g = 0; g < `PDM_NUM_CH; g++) begin : g_ch
		pdm_pid_route u_route (
			.pclk    (pclk),
			.presetn (presetn),
			.pid     (s_r.psel[g]),
			.rx_req  (periph_rx_req),
			.tx_req  (periph_tx_req),
			.req     (chan_req[g]),
			.is_tx   (chan_is_tx[g])
		);
	end

	// ********************
	// checks
	// ********************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// answers are registered, so read checks look one cycle on

	sequence sq_rd_setup(logic [11:0] a);
		setup && !pwrite && paddr == a;
	endsequence

	sequence sq_clr1_then_idle;
		clr1 ##1 !ch1_wr_init;
	endsequence

	sequence sq_clr0_then_idle;
		clr0 ##1 !ch0_wr_init;
	endsequence

	sequence sq_psel_write;
		wr_take && is_psel_addr(paddr);
	endsequence

	chk_data_count: assert property (
		!clr1 |=> s_r.dat1 == $past(s_r.dat1) + 32'($past(ch1_wr_data)))
		else $error("data cycle count off");

	chk_stall_count: assert property (
		clr1 |=> s_r.stl1 == 32'($past(ch1_wr_stall)))
		else $error("stall count not restarted by clear");

	chk_lat_read: assert property (
		sq_rd_setup(`PDM_OFF_CH1_WR_LAT) |=>
			pready && prdata[31:16] == 16'h0000 && prdata[15:0] == $past(max1))
		else $error("latency read wrong");

	chk_lat_sat_top: assert property (
		max1 == 16'hffff && !clr1 |=> max1 == 16'hffff)
		else $error("channel 1 maximum wrapped");

	chk_lat1_keep: assert property (
		!clr1 |=> max1 >= $past(max1))
		else $error("channel 1 maximum fell without clear");

	chk_lat1_clear: assert property (
		sq_clr1_then_idle |-> max1 == 16'h0000 || $past(ch1_wr_init))
		else $error("channel 1 clear did not empty maximum");

	chk_lat0_keep: assert property (
		!clr0 |=> max0 >= $past(max0))
		else $error("channel 0 maximum fell without clear");

	chk_rev_read: assert property (
		sq_rd_setup(`PDM_OFF_REV_INFO) |=>
			prdata[11:0] == REV_VERSION && prdata[31:20] == 12'h000
			&& prdata[15:12] == 4'h0)
		else $error("revision word wrong");

	chk_psel_reset: assert property (
		!s_r.seen |-> s_r.psel[0] == reset_psel(0)
			&& s_r.psel[5] == reset_psel(5) && s_r.psel[7] == reset_psel(7))
		else $error("select not at channel index after reset");

	chk_tx_dir: assert property (
		s_r.psel[0] == 5'h17 |=> chan_is_tx[0] && chan_req[0] == $past(periph_tx_req[11]))
		else $error("last identifier not routed as transmit");

	chk_unmapped: assert property (
		setup && paddr == 12'h020 |=> pslverr && prdata == 32'h00000000)
		else $error("ninth channel select answered");

	chk_stall_keep: assert property (
		!clr1 |=> s_r.stl1 == $past(s_r.stl1) + 32'($past(ch1_wr_stall)))
		else $error("stall cycle count off");

	chk_data_clear: assert property (
		clr1 |=> s_r.dat1 == 32'($past(ch1_wr_data)))
		else $error("data count not restarted by clear");

	chk_lat0_clear: assert property (
		sq_clr0_then_idle |-> max0 == 16'h0000 || $past(ch0_wr_init))
		else $error("channel 0 clear did not empty maximum");

	chk_variant_read: assert property (
		sq_rd_setup(`PDM_OFF_REV_INFO) |=> prdata[19:16] == REV_VARIANT && !pslverr)
		else $error("variant field wrong");

	chk_sel_store: assert property (
		sq_psel_write |=> s_r.psel[$past(paddr[4:2])] == $past(pwdata[4:0]))
		else $error("channel select write lost");

	chk_sel_read: assert property (
		sq_rd_setup(`PDM_OFF_PSEL_BASE) |=> prdata == {27'h0000000, $past(s_r.psel[0])})
		else $error("channel select read wrong");

	chk_rx_dir: assert property (
		s_r.psel[1] < 5'h0c |=> !chan_is_tx[1]
			&& chan_req[1] == $past(periph_rx_req[s_r.psel[1][3:0]]))
		else $error("receive identifier not routed as receive");

	chk_no_source: assert property (
		s_r.psel[7] > `PDM_PID_LAST |=> !chan_req[7] && !chan_is_tx[7])
		else $error("identifier past the last one routed");

	// one answer per transfer keeps back-to-back setups apart
	chk_ready_pulse: assert property (
		pready |=> !pready)
		else $error("ready held past one cycle");

	chk_err_ready: assert property (
		pslverr |-> pready)
		else $error("error flagged outside an answer");

	chk_cnt_ro: assert property (
		wr_take && paddr == `PDM_OFF_CH1_WR_DAT && !ch1_wr_data
			|=> s_r.dat1 == $past(s_r.dat1))
		else $error("data count changed by a write");

	chk_lat0_read: assert property (
		sq_rd_setup(`PDM_OFF_CH0_WR_LAT) |=> prdata == {16'h0000, $past(max0)})
		else $error("channel 0 latency read wrong");

	chk_stall_read: assert property (
		sq_rd_setup(`PDM_OFF_CH1_WR_STL) |=> prdata == $past(s_r.stl1))
		else $error("stall count read wrong");

	chk_data_read: assert property (
		sq_rd_setup(`PDM_OFF_CH1_WR_DAT) |=> prdata == $past(s_r.dat1))
		else $error("data count read wrong");

endmodule : pdm_top

//--- hdl/pdm_cfg.svh
// Purpose: offsets, field positions, reset values of the dma perf block
// Assumes: byte addresses on a 12-bit apb address
// Notes:   definitions only
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH

// ********************
// register offsets
// ********************
`define PDM_OFF_PSEL_BASE  12'h000
`define PDM_OFF_PERF_CTRL  12'h800
`define PDM_OFF_CH0_WR_LAT 12'h818
`define PDM_OFF_CH1_WR_DAT 12'h828
`define PDM_OFF_CH1_WR_STL 12'h82c
`define PDM_OFF_CH1_WR_LAT 12'h830
`define PDM_OFF_REV_INFO   12'h834

// ********************
// fields and sizes
// ********************
`define PDM_CH0_CLR_BIT    0
`define PDM_CH1_CLR_BIT    1
`define PDM_NUM_CH         8
`define PDM_RX_IDS         12
`define PDM_PID_LAST       5'h17
`define PDM_VARIANT_LSB    16
`define PDM_LAT_SAT        16'hffff
`define PDM_RST_WORD       32'h00000000

`endif

//--- hdl/pdm_pkg.sv
// Purpose: types shared by the dma perf and id-map block
// Assumes: pdm_cfg.svh holds the numbers
// Notes:   state of each module is one packed struct
package pdm_pkg;

	typedef logic [31:0] pdm_word_t;
	typedef logic [15:0] pdm_lat_t;
	typedef logic [4:0]  pdm_pid_t;

	// identifier order: receive block then transmit block
	typedef enum logic [4:0] {
		pid_adc_rx = 5'h00, pid_sync_rx = 5'h01, pid_uart0_rx = 5'h02,
		pid_uart1_rx = 5'h03, pid_uart2_rx = 5'h04, pid_uart3_rx = 5'h05,
		pid_twm_a_rx = 5'h06, pid_twm_b_rx = 5'h07, pid_tws_a_rx = 5'h08,
		pid_tws_b_rx = 5'h09, pid_spi_a_rx = 5'h0a, pid_spi_b_rx = 5'h0b,
		pid_sync_tx = 5'h0c, pid_uart0_tx = 5'h0d, pid_uart1_tx = 5'h0e,
		pid_uart2_tx = 5'h0f, pid_uart3_tx = 5'h10, pid_twm_a_tx = 5'h11,
		pid_twm_b_tx = 5'h12, pid_tws_a_tx = 5'h13, pid_tws_b_tx = 5'h14,
		pid_spi_a_tx = 5'h15, pid_spi_b_tx = 5'h16, pid_audio_tx = 5'h17
	} pdm_pid_name_t;

	typedef struct packed {
		pdm_lat_t cur;
		pdm_lat_t max;
	} pdm_lat_st_t;

	typedef struct packed {
		logic req;
		logic is_tx;
	} pdm_route_st_t;

	typedef struct packed {
		pdm_pid_t [7:0] psel;
		pdm_word_t      dat1;
		pdm_word_t      stl1;
		pdm_word_t      prdata;
		logic           pready;
		logic           pslverr;
		logic           seen;
	} pdm_top_st_t;

	function automatic pdm_word_t pdm_cnt_next(pdm_word_t v, logic ev, logic clr);
		pdm_word_t b;
		b = clr ? 32'h00000000 : v;
		return b + {31'h00000000, ev};
	endfunction : pdm_cnt_next

	function automatic pdm_lat_t pdm_sat_inc(pdm_lat_t v);
		return (v == 16'hffff) ? v : v + 16'h0001;
	endfunction : pdm_sat_inc

endpackage : pdm_pkg

//--- hdl/pdm_lat_track.sv
// Purpose: saturating max initiation latency tracker for one channel
// Assumes: busy is high for every cycle of one transfer initiation
// Notes:   only clr or reset empties the maximum
`include "pdm_cfg.svh"
module pdm_lat_track (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// activity
	input  wire logic          busy,
	input  wire logic          clr,
	// result
	output pdm_pkg::pdm_lat_t  max_lat
);
	import pdm_pkg::*;

	pdm_lat_st_t s_r;
	pdm_lat_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.cur = busy ? pdm_sat_inc(s_r.cur) : 16'h0000;
		s_nxt.max = clr ? 16'h0000 : s_r.max;
		// a run in progress survives the clear: set wins
		if (busy && s_nxt.cur > s_nxt.max) begin
			s_nxt.max = s_nxt.cur;
		end
	end

	// counted on the dma bus clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign max_lat = s_r.max;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_sat_hold: assert property (
		(s_r.max == `PDM_LAT_SAT) && !clr |=> s_r.max == `PDM_LAT_SAT)
		else $error("saturated latency left all ones");
	chk_run_tracked: assert property (
		busy [*3] |-> s_r.max >= 16'h0002)
		else $error("latency run not reflected in maximum");

endmodule : pdm_lat_track

//--- hdl/pdm_pid_route.sv
// Purpose: handshake source select for one channel
// Assumes: request vectors indexed by identifier order
// Notes:   identifiers above the last select nothing
`include "pdm_cfg.svh"
module pdm_pid_route (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// selection
	input  wire pdm_pkg::pdm_pid_t pid,
	input  wire logic [11:0]      rx_req,
	input  wire logic [11:0]      tx_req,
	// result
	output logic                  req,
	output logic                  is_tx
);
	import pdm_pkg::*;

	pdm_route_st_t s_r;
	pdm_route_st_t s_nxt;

	always_comb begin
		s_nxt = '0;
		if (pid < 5'(`PDM_RX_IDS)) begin
			s_nxt.req = rx_req[pid[3:0]];
		end else if (pid <= `PDM_PID_LAST) begin
			s_nxt.req   = tx_req[4'(pid - 5'(`PDM_RX_IDS))];
			s_nxt.is_tx = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign req   = s_r.req;
	assign is_tx = s_r.is_tx;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_rx_route: assert property (
		pid < 5'h0c |=> !is_tx && req == $past(rx_req[pid[3:0]]))
		else $error("receive identifier routed wrongly");
	chk_tx_route: assert property (
		pid >= 5'h0c && pid <= 5'h17 |=> is_tx)
		else $error("transmit identifier not flagged transmit");

endmodule : pdm_pid_route

//--- verification/pdm_periph_model.sv
// Purpose: peripheral side, raising receive and transmit handshake requests
// Assumes: requests change just after a rising edge of pclk
// Notes:   fresh random pattern every cycle, quiet in reset
module pdm_periph_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// handshake requests
	output logic [11:0]      rx_req,
	output logic [11:0]      tx_req
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_req <= 12'h000;
			tx_req <= 12'h000;
		end else begin
			rx_req <= 12'($urandom);
			tx_req <= 12'($urandom);
		end
	end
endmodule : pdm_periph_model

//--- verification/testbench.sv
// Purpose: self-checking bench of the dma perf and identifier map block
// Assumes: zero or more wait states on apb, one cycle routing latency
// Notes:   saturation run is long, about 65k cycles
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pdm_pkg::*;
	localparam logic [11:0] REV_V = 12'h0a5; // arbitrary value
	localparam logic [3:0]  REV_A = 4'h3;    // arbitrary value
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	pdm_word_t   pwdata = 0, prdata, rd;
	logic        pready, pslverr, er, route_on = 0;
	logic        ch0_wr_init = 0, ch1_wr_init = 0, ch1_wr_data = 0, ch1_wr_stall = 0;
	logic [11:0] rx_req, tx_req, rx_q, tx_q;
	logic [7:0]  chan_req, chan_is_tx;
	logic [4:0]  sel_m [8];
	logic [1:0]  b;
	int          errors = 0, total_checks = 0, cyc = 0, nd, ns, m1, len, n, r;
	always #4 pclk = ~pclk;
	pdm_top #(.REV_VERSION(REV_V), .REV_VARIANT(REV_A)) i_pdm_top (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch0_wr_init(ch0_wr_init), .ch1_wr_init(ch1_wr_init), .ch1_wr_data(ch1_wr_data),
		.ch1_wr_stall(ch1_wr_stall), .periph_rx_req(rx_req), .periph_tx_req(tx_req),
		.chan_req(chan_req), .chan_is_tx(chan_is_tx));
	pdm_periph_model i_pdm_periph_model (.pclk(pclk), .presetn(presetn),
		.rx_req(rx_req), .tx_req(tx_req));
	// ********************
	// checking helpers
	// ********************
	task chk(input pdm_word_t seen, input pdm_word_t exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task complete_run;
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task apb(input logic wr, input logic [11:0] a, input pdm_word_t wd);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		// only the bench timeout ends a wait that never answers
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rdchk(input logic [11:0] a, input pdm_word_t exp);
		apb(0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// init held high for exactly len sampled edges
	task burst(input int l, input logic ch);
		@(posedge pclk);
		if (ch) ch1_wr_init <= 1; else ch0_wr_init <= 1;
		repeat (l) @(posedge pclk);
		ch1_wr_init <= 0;
		ch0_wr_init <= 0;
	endtask : burst
	function automatic logic [1:0] route_exp(logic [4:0] p);
		if (p < 12) return {1'b0, rx_q[p]};
		if (p < 24) return {1'b1, tx_q[p - 12]};
		return 2'b00;
	endfunction : route_exp
	// ********************
	// routing and timeout monitors
	// ********************
	always @(posedge pclk) begin
		rx_q <= rx_req;
		tx_q <= tx_req;
		cyc++;
		if (cyc == 90000) begin
			errors++;
			complete_run;
		end
	end
	always @(negedge pclk) if (route_on) for (int c = 0; c < 8; c++)
		chk({30'h0, chan_is_tx[c], chan_req[c]}, {30'h0, route_exp(sel_m[c])});
	// ********************
	// main sequence
	// ********************
	initial begin
		void'($urandom(44));
		for (n = 0; n < 8; n++) sel_m[n] = 5'(n);
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (n = 0; n < 8; n++) rdchk(12'(4 * n), pdm_word_t'(n));
		apb(0, 12'h020, 32'h0);
		chk({31'h0, er}, 32'h1);
		rdchk(12'h828, 32'h0);
		rdchk(12'h82c, 32'h0);
		rdchk(12'h830, 32'h0);
		rdchk(12'h834, {12'h000, REV_A, 4'h0, REV_V});
		apb(1, 12'h834, 32'hffffffff);
		rdchk(12'h834, {12'h000, REV_A, 4'h0, REV_V});
		nd = 0;
		ns = 0;
		repeat (300) begin
			@(posedge pclk);
			b = 2'($urandom);
			ch1_wr_data <= b[0];
			ch1_wr_stall <= b[1];
			nd += b[0];
			ns += b[1];
		end
		@(posedge pclk);
		ch1_wr_data <= 0;
		ch1_wr_stall <= 0;
		rdchk(12'h828, pdm_word_t'(nd));
		rdchk(12'h82c, pdm_word_t'(ns));
		apb(1, 12'h828, 32'hffffffff);
		rdchk(12'h828, pdm_word_t'(nd));
		m1 = 0;
		repeat (6) begin
			len = 1 + $urandom % 40;
			if (len > m1) m1 = len;
			burst(len, 1);
		end
		burst(7, 0);
		rdchk(12'h830, pdm_word_t'(m1));
		apb(1, 12'h800, 32'h0);
		apb(1, 12'h830, 32'h0);
		rdchk(12'h830, pdm_word_t'(m1));
		apb(1, 12'h800, 32'h2);
		rdchk(12'h830, 32'h0);
		rdchk(12'h828, 32'h0);
		rdchk(12'h818, 32'h7);
		apb(1, 12'h800, 32'h1);
		rdchk(12'h818, 32'h0);
		burst(65540, 1);
		rdchk(12'h830, 32'h0000ffff);
		for (r = 0; r < 4; r++) begin
			for (n = 0; n < 8; n++) begin
				sel_m[n] = (r < 3) ? 5'(8 * r + n) : 5'($urandom % 24);
				if (r == 3 && n == 7) sel_m[n] = 5'h1f;
				if (r == 3 && n == 0) sel_m[n] = 5'h17;
				apb(1, 12'(4 * n), {27'h0, sel_m[n]});
			end
			repeat (2) @(posedge pclk);
			route_on = 1;
			repeat (20) @(posedge pclk);
			route_on = 0;
		end
		// mid-run reset must restore selects and empty the saturated maximum
		@(posedge pclk);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		for (n = 0; n < 8; n++) rdchk(12'(4 * n), pdm_word_t'(n));
		rdchk(12'h830, 32'h0);
		rdchk(12'h82c, 32'h0);
		complete_run;
	end
endmodule : testbench
